// ---- hdl/pllc_ctrl.sv ----
// Top of the PLL settings control block: Avalon-MM registers for the
// two core PLLs and the cluster PLL, driving the analog macro settings.
// Assumes one 100 MHz clock and a synchronous active-low reset.
// How it works
// - each PLL owns a main control and a divider control register
// - enable bit 31 resets to one; PLL waits for software writing one
// - main bits 25:20 hold reference divider, reset one
// - main bits 19:8 hold feedback divider; core PLLs reset to 48
// - cluster PLL feedback divider resets to 0x20, dividing by 32
// - main bit 0 bypasses PLL with input clock; resets to zero
// - divider bits 30:28 hold second post divider directly, reset one
// - divider bits 26:24 hold first post divider directly, reset one
// - divider bits 23:0 hold fraction over two to twenty-four, reset zero
`timescale 1ns/10ps
module pllc_ctrl
  import pllc_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_b,
  input  wire logic [4:0]              avs_address,
  input  wire logic                    avs_read,
  input  wire logic                    avs_write,
  input  wire logic [31:0]             avs_writedata,
  input  wire logic [3:0]              avs_byteenable,
  output logic      [31:0]             avs_readdata,
  output logic                         avs_waitrequest,
  output logic      [2:0]              pll_global_enable,
  output logic      [2:0][5:0]         reference_divider,
  output logic      [2:0][11:0]        feedback_divider,
  output logic      [2:0]              pll_direct_bypass,
  output logic      [2:0][2:0]         first_post_divider,
  output logic      [2:0][2:0]         second_post_divider,
  output logic      [2:0][23:0]        feedback_fraction
);
  import pllc_pkg::*;

  pllc_reg_if       rif ();
  logic [2:0][31:0] main_ctrl;
  logic [2:0][31:0] divider_ctrl;

  pllc_bus_slave u_slave (
    .clk_sys         (clk_sys),
    .rst_b           (rst_b),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rif             (rif)
  );

  // Register pair per PLL; cluster differs only in its main reset
  for (genvar g = 0; g < PLLC_NUM_PLL; g++) begin : g_pll
    logic wr_main;
    logic wr_div;
    assign wr_main = rif.wr_stb && (rif.idx == 3'(2 * g));
    assign wr_div  = rif.wr_stb && (rif.idx == 3'(2 * g + 1));

    pllc_pll_regs #(
      .MAIN_RST (PLLC_MAIN_RST[g])
    ) u_regs (
      .clk_sys           (clk_sys),
      .rst_b             (rst_b),
      .wr_main           (wr_main),
      .wr_div            (wr_div),
      .wdata             (rif.wdata),
      .be                (rif.be),
      .main_ctrl         (main_ctrl[g]),
      .divider_ctrl      (divider_ctrl[g]),
      .pll_global_enable (pll_global_enable[g])
    );

    // Fields go to the macro straight from the register flops
    assign reference_divider[g] =
      main_ctrl[g][PLLC_REF_DIV_LSB +: PLLC_REF_DIV_W];
    assign feedback_divider[g] =
      main_ctrl[g][PLLC_FB_DIV_LSB +: PLLC_FB_DIV_W];
    // Clock selection itself lives in the macro; we only steer it
    assign pll_direct_bypass[g] = main_ctrl[g][PLLC_BYP_BIT];
    // Field value is the divide ratio, no offset
    assign second_post_divider[g] =
      divider_ctrl[g][PLLC_PD2_LSB +: PLLC_PD_W];
    assign first_post_divider[g] =
      divider_ctrl[g][PLLC_PD1_LSB +: PLLC_PD_W];
    assign feedback_fraction[g] =
      divider_ctrl[g][PLLC_FRACTION_LSB +: PLLC_FRACTION_W];
  end

  // Read back; unmapped words read zero and writes there are dropped
  always_comb begin
    case (rif.idx)
      PLLC_OFS_CORE0_MAIN[4:2]: rif.rdata = main_ctrl[0];
      PLLC_OFS_CORE0_DIV[4:2]:  rif.rdata = divider_ctrl[0];
      PLLC_OFS_CORE1_MAIN[4:2]: rif.rdata = main_ctrl[1];
      PLLC_OFS_CORE1_DIV[4:2]:  rif.rdata = divider_ctrl[1];
      PLLC_OFS_CLUS_MAIN[4:2]:  rif.rdata = main_ctrl[2];
      PLLC_OFS_CLUS_DIV[4:2]:   rif.rdata = divider_ctrl[2];
      default:                  rif.rdata = 32'h0000_0000;
    endcase
  end

  // Helper: first cycle after reset release
  logic first_cycle;
  always_ff @(posedge clk_sys) begin
    first_cycle <= !rst_b;
  end

  sequence main_reset_s;
    main_ctrl[0] == PLLC_CORE_MAIN_RST && main_ctrl[1] == PLLC_CORE_MAIN_RST;
  endsequence

  sequence fields_reset_s;
    reference_divider[2] == 6'h01 && feedback_divider[2] == 12'h020
      && pll_direct_bypass == 3'b000 && first_post_divider[0] == 3'h1
      && second_post_divider[1] == 3'h1 && feedback_fraction[2] == 24'h0;
  endsequence

  reset_values_a: assert property (@(posedge clk_sys)
    (first_cycle && rst_b) |-> main_reset_s and fields_reset_s)
    else $error("register values after reset are wrong");

  disabled_boot_a: assert property (@(posedge clk_sys)
    (first_cycle && rst_b) |-> pll_global_enable == 3'b000)
    else $error("a PLL is enabled straight after reset");

  bypass_write_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (rif.wr_stb && rif.idx == 3'h4 && rif.be[0])
      |=> pll_direct_bypass[2] == $past(rif.wdata[0]))
    else $error("bypass bit not written");

  ref_div_write_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (rif.wr_stb && rif.idx == 3'h2 && rif.be[3:2] == 2'b11)
      |=> reference_divider[1] == $past(rif.wdata[25:20]))
    else $error("reference divider not written");

  unmapped_zero_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (rif.idx[2:1] == 2'b11) |-> rif.rdata == 32'h0000_0000)
    else $error("unmapped address reads non-zero");
endmodule

// ---- hdl/pllc_pkg.sv ----
// Constants shared by the PLL settings control block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package pllc_pkg;

  localparam int PLLC_NUM_PLL = 3;

  // Byte offsets of the six registers; each takes one aligned word
  localparam logic [4:0] PLLC_OFS_CORE0_MAIN = 5'h00;
  localparam logic [4:0] PLLC_OFS_CORE0_DIV  = 5'h04;
  localparam logic [4:0] PLLC_OFS_CORE1_MAIN = 5'h08;
  localparam logic [4:0] PLLC_OFS_CORE1_DIV  = 5'h0C;
  localparam logic [4:0] PLLC_OFS_CLUS_MAIN  = 5'h10;
  localparam logic [4:0] PLLC_OFS_CLUS_DIV   = 5'h14;

  // Main control register fields
  localparam int PLLC_EN_BIT     = 31;
  localparam int PLLC_REF_DIV_LSB = 20;
  localparam int PLLC_REF_DIV_W   = 6;
  localparam int PLLC_FB_DIV_LSB  = 8;
  localparam int PLLC_FB_DIV_W    = 12;
  localparam int PLLC_BYP_BIT    = 0;

  // Divider control register fields
  localparam int PLLC_PD2_LSB  = 28;
  localparam int PLLC_PD1_LSB  = 24;
  localparam int PLLC_PD_W     = 3;
  localparam int PLLC_FRACTION_LSB = 0;
  localparam int PLLC_FRACTION_W   = 24;

  // Writable bits; everything else is reserved and reads zero
  localparam logic [31:0] PLLC_MAIN_MASK = 32'h83FF_FF01;
  localparam logic [31:0] PLLC_DIV_MASK  = 32'h77FF_FFFF;

  // Values after reset, index 0 core0, 1 core1, 2 cluster
  localparam logic [31:0] PLLC_CORE_MAIN_RST = 32'h8010_3000;
  localparam logic [31:0] PLLC_CLUS_MAIN_RST = 32'h8010_2000;
  localparam logic [31:0] PLLC_DIV_RST       = 32'h1100_0000;
  localparam logic [2:0][31:0] PLLC_MAIN_RST = {PLLC_CLUS_MAIN_RST,
                                                PLLC_CORE_MAIN_RST,
                                                PLLC_CORE_MAIN_RST};

  typedef enum logic [1:0] {
    PLLC_ST_IDLE = 2'b01,
    PLLC_ST_ACK  = 2'b10
  } pllc_bus_state_t;

endpackage

// ---- hdl/pllc_reg_if.sv ----
// Internal register access strobes between bus slave and register banks.
// Assumes a single clock shared by both ends.
`timescale 1ns/10ps
interface pllc_reg_if;
  logic        wr_stb;
  logic [2:0]  idx;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;

  modport bus  (output wr_stb, output idx, output wdata, output be,
                input rdata);
  modport bank (input wr_stb, input idx, input wdata, input be,
                output rdata);
endinterface

// ---- hdl/pllc_bus_slave.sv ----
// Avalon-MM slave front end with a fixed one-cycle wait state.
// Assumes the master holds its request until waitrequest is low.
`timescale 1ns/10ps
module pllc_bus_slave
  import pllc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  pllc_reg_if.bus          rif
);
  import pllc_pkg::*;

  typedef struct packed {
    pllc_bus_state_t state;
    logic [31:0]     rdata;
  } pllc_slave_st_t;

  pllc_slave_st_t cur;
  pllc_slave_st_t next_cur;
  logic           req;

  assign req             = avs_read | avs_write;
  // Waitrequest drops in the second cycle of every request
  assign avs_waitrequest = req && (cur.state != PLLC_ST_ACK);
  assign avs_readdata    = cur.rdata;
  assign rif.wr_stb      = avs_write && (cur.state == PLLC_ST_ACK);
  assign rif.idx         = avs_address[4:2];
  assign rif.wdata       = avs_writedata;
  assign rif.be          = avs_byteenable;

  always_comb begin
    next_cur = cur;
    case (cur.state)
      PLLC_ST_IDLE: begin
        if (req) begin
          next_cur.state = PLLC_ST_ACK;
        end
        // Capture a cycle early so read data come from a flop
        if (avs_read) begin
          next_cur.rdata = rif.rdata;
        end
      end
      PLLC_ST_ACK: begin
        next_cur.state = PLLC_ST_IDLE;
      end
      default: begin
        next_cur.state = PLLC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cur <= '{state: PLLC_ST_IDLE, rdata: 32'h0000_0000};
    end else begin
      cur <= next_cur;
    end
  end

  wait_one_cycle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("waitrequest not released after one cycle");

  read_data_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (avs_read && !avs_waitrequest) |-> $past(rif.rdata) == avs_readdata)
    else $error("read data differ from the addressed register");
endmodule

// ---- hdl/pllc_pll_regs.sv ----
// Main and divider control registers for one PLL.
// Assumes write strobes are one-cycle pulses on clk_sys.
`timescale 1ns/10ps
module pllc_pll_regs
  import pllc_pkg::*;
#(
  parameter logic [31:0] MAIN_RST = 32'h8010_3000
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        wr_main,
  input  wire logic        wr_div,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  be,
  output logic      [31:0] main_ctrl,
  output logic      [31:0] divider_ctrl,
  output logic             pll_global_enable
);
  import pllc_pkg::*;

  typedef struct packed {
    logic [31:0] main_ctrl;
    logic [31:0] divider_ctrl;
    logic        armed;
  } pllc_pll_st_t;

  pllc_pll_st_t cur;
  pllc_pll_st_t next_cur;
  logic [31:0]  be_mask;

  assign be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};

  always_comb begin
    next_cur = cur;
    // Reserved bits never take a write
    if (wr_main) begin
      next_cur.main_ctrl = (cur.main_ctrl & ~(be_mask & PLLC_MAIN_MASK))
                         | (wdata & be_mask & PLLC_MAIN_MASK);
      if (be[3] && wdata[PLLC_EN_BIT]) begin
        next_cur.armed = 1'b1;
      end
    end
    if (wr_div) begin
      next_cur.divider_ctrl = (cur.divider_ctrl & ~(be_mask & PLLC_DIV_MASK))
                            | (wdata & be_mask & PLLC_DIV_MASK);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cur <= '{main_ctrl: MAIN_RST, divider_ctrl: PLLC_DIV_RST,
               armed: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign main_ctrl    = cur.main_ctrl;
  assign divider_ctrl = cur.divider_ctrl;
  // Bit reads one from reset, yet the PLL waits for a written one
  assign pll_global_enable = cur.main_ctrl[PLLC_EN_BIT] & cur.armed;

  // Enable may only rise on the cycle after a written one in bit 31
  boot_disabled_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(pll_global_enable)
      |-> $past(wr_main && be[3] && wdata[PLLC_EN_BIT]))
    else $error("PLL enabled without a written enable bit");

  enable_write_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (wr_main && be[3] && wdata[PLLC_EN_BIT]) |=> pll_global_enable)
    else $error("enable write did not enable the PLL");

  main_reserved_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (main_ctrl & ~PLLC_MAIN_MASK) == 32'h0000_0000)
    else $error("reserved main bits not zero");

  div_reserved_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (divider_ctrl & ~PLLC_DIV_MASK) == 32'h0000_0000)
    else $error("reserved divider bits not zero");

  div_write_a: assert property (
    @(posedge clk_sys) disable iff (!rst_b)
    (wr_div && be == 4'hF)
      |=> divider_ctrl == ($past(wdata) & PLLC_DIV_MASK))
    else $error("divider write not stored");
endmodule

// ---- verification/pllc_macro_model.sv ----
// Behavioural stand-in for one analog PLL macro fed by the settings.
// Assumes the settings are static levels from the register bank.
`timescale 1ns/10ps
module pllc_macro_model (
  input  wire logic        pll_global_enable,
  input  wire logic [5:0]  reference_divider,
  input  wire logic [11:0] feedback_divider,
  input  wire logic        pll_direct_bypass,
  input  wire logic [2:0]  first_post_divider,
  input  wire logic [2:0]  second_post_divider,
  input  wire logic [23:0] feedback_fraction,
  output logic             uses_input_clk,
  output logic             vco_running,
  output logic [5:0]       post_divide,
  output logic [35:0]      feedback_q24
);
  // Bypass routes the reference straight through, PLL output unused
  assign uses_input_clk = pll_direct_bypass;
  // A zero reference divide cannot lock, so the VCO is held off
  assign vco_running = pll_global_enable && (reference_divider != 6'h0);
  // Both post dividers divide by their field value as it stands
  assign post_divide = first_post_divider
                     * second_post_divider;
  // Integer part above a 24-bit fraction
  assign feedback_q24 = {feedback_divider, feedback_fraction};
endmodule

// ---- verification/pllc_ctrl_tb.sv ----
// Self-checking bench for the PLL settings control block.
// Assumes the Avalon-MM slave answers after one wait cycle or more.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module pllc_ctrl_tb;
  import pllc_pkg::*;
  logic             clk_sys = 1'b0;
  logic             rst_b = 1'b0;
  logic [4:0]       avs_address = 5'h00;
  logic             avs_read = 1'b0;
  logic             avs_write = 1'b0;
  logic [31:0]      avs_writedata = 32'h0000_0000;
  logic [3:0]       avs_byteenable = 4'h0;
  logic [31:0]      avs_readdata;
  logic             avs_waitrequest;
  logic [2:0]       en, byp;
  logic [2:0][5:0]  rdiv;
  logic [2:0][11:0] fdiv;
  logic [2:0][2:0]  pd1, pd2;
  logic [2:0][23:0] fract;
  logic [2:0]       m_inp, m_run;
  logic [2:0][5:0]  m_pd;
  logic [2:0][35:0] m_fb;
  logic [31:0]      q;
  logic [31:0]      exp_main;
  int               n_errors = 0;
  int               n_tests = 0;

  always #5 clk_sys = ~clk_sys;

  pllc_ctrl i_pllc_ctrl (.clk_sys(clk_sys), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pll_global_enable(en), .reference_divider(rdiv),
    .feedback_divider(fdiv), .pll_direct_bypass(byp),
    .first_post_divider(pd1), .second_post_divider(pd2),
    .feedback_fraction(fract));

  for (genvar g = 0; g < 3; g++) begin : g_mac
    pllc_macro_model i_pllc_macro_model (.pll_global_enable(en[g]),
      .reference_divider(rdiv[g]), .feedback_divider(fdiv[g]),
      .pll_direct_bypass(byp[g]), .first_post_divider(pd1[g]),
      .second_post_divider(pd2[g]), .feedback_fraction(fract[g]),
      .uses_input_clk(m_inp[g]), .vco_running(m_run[g]),
      .post_divide(m_pd[g]), .feedback_q24(m_fb[g]));
  end

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_errors++;
      $display("[FAIL] bus answer expected 0 seen %h", avs_waitrequest);
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, 4'h0);
    `CHK("readback", e, q)
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      exp_main = (i == 2) ? 32'h8010_2000 : 32'h8010_3000;
      rd_chk(5'(8 * i), exp_main);
      rd_chk(5'(8 * i + 4), 32'h1100_0000);
      `CHK("ref_div", 6'h01, rdiv[i])
      `CHK("bypass", 1'b0, m_inp[i])
      `CHK("postdiv", 6'h01, m_pd[i])
      `CHK("fraction", 24'h00_0000, fract[i])
      `CHK("vco", 1'b0, m_run[i])
    end
    `CHK("fb_div1", 12'h030, fdiv[1])
    `CHK("fb_div2", 12'h020, fdiv[2])
    `CHK("enable", 3'b000, en)
    $display("reset values done");
    // Top lane masked off: enable bit must stay unwritten and unarmed
    bus(1'b1, 5'h08, 32'h0000_0000, 4'b0111);
    rd_chk(5'h08, 32'h8000_0000);
    `CHK("enable", 3'b000, en)
    $display("byte lanes done");
    for (int i = 0; i < 3; i++) begin
      bus(1'b1, 5'(8 * i), 32'hFFFF_FFFF, 4'hF);
      bus(1'b1, 5'(8 * i + 4), 32'hFFFF_FFFF, 4'hF);
      rd_chk(5'(8 * i), 32'h83FF_FF01);
      rd_chk(5'(8 * i + 4), 32'h77FF_FFFF);
      `CHK("enable", 1'b1, en[i])
      `CHK("vco", 1'b1, m_run[i])
      `CHK("fb_div", 12'hFFF, fdiv[i])
      `CHK("ref_div", 6'h3F, rdiv[i])
      `CHK("pd2", 3'h7, pd2[i])
      `CHK("bypass", 1'b1, m_inp[i])
    end
    $display("all ones done");
    // Non-default settings, as software may later choose
    bus(1'b1, 5'h00, 32'h02A5_A501, 4'hF);
    bus(1'b1, 5'h04, 32'h3500_0123, 4'hF);
    rd_chk(5'h00, 32'h02A5_A501);
    `CHK("enable", 3'b110, en)
    `CHK("ref_div", 6'h2A, rdiv[0])
    `CHK("fb", 36'h5A5_000123, m_fb[0])
    `CHK("pd1", 3'h5, pd1[0])
    `CHK("pd2", 3'h3, pd2[0])
    `CHK("postdiv", 6'd15, m_pd[0])
    $display("field pattern done");
    bus(1'b1, 5'h18, 32'hFFFF_FFFF, 4'hF);
    rd_chk(5'h18, 32'h0000_0000);
    rd_chk(5'h1C, 32'h0000_0000);
    rd_chk(5'h10, 32'h83FF_FF01);
    $display("unmapped done");
    // A second reset must drop every enable until bit 31 is written again
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(5'h10, 32'h8010_2000);
    rd_chk(5'h04, 32'h1100_0000);
    `CHK("enable", 3'b000, en)
    `CHK("vco", 1'b0, m_run[0])
    bus(1'b1, 5'h00, 32'h8000_0000, 4'b1000);
    rd_chk(5'h00, 32'h8010_3000);
    `CHK("enable", 3'b001, en)
    $display("second reset done");
    give_verdict();
  end
endmodule
